// >>> rtl/acp_pkg.sv
// shared constants and carrier types of the converter control block
package acp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STARTUP_TIME_NS = 5000;
  localparam int unsigned STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STARTUP_COUNT = 10'(STARTUP_CYCLES);
  localparam logic [2:0] TAIL_BUS_CYCLES = 3'h5;
  localparam logic [2:0] TAIL_NEXT_CYCLES = 3'h1;

  // conversion-clock cycle budgets
  localparam logic [5:0] FIRST_SHORT_8 = 6'h14;
  localparam logic [5:0] FIRST_SHORT_10 = 6'h17;
  localparam logic [5:0] FIRST_LONG_8 = 6'h28;
  localparam logic [5:0] FIRST_LONG_10 = 6'h2b;
  localparam logic [5:0] NEXT_SHORT_8 = 6'h11;
  localparam logic [5:0] NEXT_SHORT_10 = 6'h14;
  localparam logic [5:0] NEXT_LONG_8 = 6'h25;
  localparam logic [5:0] NEXT_LONG_10 = 6'h28;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_10 = 4'ha;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PIN_DISABLE = 8'h0c;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h14;

  localparam int unsigned CFG_CLKSEL_LSB = 0;
  localparam int unsigned CFG_DIV_LSB = 2;
  localparam int unsigned CFG_LONG_BIT = 4;
  localparam int unsigned CFG_MODE10_BIT = 5;
  localparam int unsigned CFG_CONT_BIT = 6;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h7f;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;

  localparam logic [1:0] CLKSEL_BUS = 2'h0;
  localparam logic [1:0] CLKSEL_BUS_HALF = 2'h1;
  localparam logic [1:0] CLKSEL_ALT = 2'h2;
  localparam logic [1:0] CLKSEL_ASYNC = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } acp_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acp_axi_rsp_type;

  typedef enum logic [1:0] {CONV_IDLE, CONV_STARTUP, CONV_RUN, CONV_TAIL} acp_conv_state_type;

endpackage : acp_pkg

// >>> rtl/acp_clk_tick.sv
// conversion clock source selection and divider
`timescale 1ns/1ps
module acp_clk_tick (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic ce, // clock enable
  input wire logic [1:0] input_clock_select, // source select
  input wire logic [1:0] clock_divide_select, // divide by 1,2,4,8
  input wire logic alternate_clock, // alternate clock pin
  input wire logic async_conversion_clock, // internal async clock
  output logic tick // one conversion clock cycle
);
  import acp_pkg::*;

  typedef struct packed {
    logic [2:0] alt_sync;
    logic [2:0] ack_sync;
    logic alt_lvl;
    logic ack_lvl;
    logic half;
    logic [2:0] div_cnt;
    logic tick;
  } acp_tick_state_type;

  acp_tick_state_type s_q;
  acp_tick_state_type s_d;
  logic src_pulse;
  logic [2:0] div_limit;

  always_comb begin
    s_d = s_q;
    src_pulse = 1'b0;
    div_limit = 3'((4'h1 << clock_divide_select) - 4'h1);
    s_d.alt_sync = {s_q.alt_sync[1:0], alternate_clock};
    s_d.ack_sync = {s_q.ack_sync[1:0], async_conversion_clock};
    // level accepted only once second and third stage agree
    if (s_q.alt_sync[1] == s_q.alt_sync[2]) begin
      s_d.alt_lvl = s_q.alt_sync[2];
    end
    if (s_q.ack_sync[1] == s_q.ack_sync[2]) begin
      s_d.ack_lvl = s_q.ack_sync[2];
    end
    s_d.half = ~s_q.half;
    case (input_clock_select)
      CLKSEL_BUS: src_pulse = 1'b1;
      CLKSEL_BUS_HALF: src_pulse = s_q.half;
      CLKSEL_ALT: src_pulse = s_d.alt_lvl & ~s_q.alt_lvl;
      CLKSEL_ASYNC: src_pulse = s_d.ack_lvl & ~s_q.ack_lvl;
      default: src_pulse = 1'b0;
    endcase
    s_d.tick = 1'b0;
    if (src_pulse) begin
      if (s_q.div_cnt >= div_limit) begin
        s_d.div_cnt = 3'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick & ce;

endmodule : acp_clk_tick

// >>> rtl/acp_adc_ctrl.sv
// converter control: clocking, pin control, conversion timing, results
// Notes on behaviour
// - two-bit select picks conversion clock source
// - pin register holds one bit per channel
// - bit high takes pin from port control
// - results written only after algorithm completes
// - short sample first: 20/23 plus 5 bus
// - long sample first: 40/43 plus 5 bus
// - async clock adds 5 us startup first
// - next short conversions take 17/20 cycles; the code takes 17/20 plus 1 bus
// - next long conversions take 37/40 cycles; the code takes 37/40 plus 1 bus
// - conversion clock is source over divider
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module acp_adc_ctrl (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic ce, // clock enable, freezes state
  input wire acp_pkg::acp_axi_req_type axi_req, // axi4-lite master side
  output acp_pkg::acp_axi_rsp_type axi_rsp, // axi4-lite slave side
  input wire logic alternate_clock, // alternate clock pin
  input wire logic async_conversion_clock, // internal async clock
  input wire logic compare_in, // comparator, high when input at or above trial
  output logic sample_hold, // sampling switch closed
  output logic [9:0] dac_code, // trial code to the analog array
  output logic convert_10bit, // resolution to the analog array
  output logic conv_busy, // conversion under way
  output logic [7:0] pin_disable // per channel port control off
);
  import acp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] cfg;
    logic [7:0] pin_dis;
    logic [1:0] res_high;
    logic [7:0] res_low;
    logic done;
    acp_conv_state_type conv;
    logic first;
    logic [9:0] startup_cnt;
    logic [5:0] rem;
    logic [2:0] tail;
    logic [9:0] code;
    logic sample;
    logic [2:0] cmp_sync;
    logic cmp_lvl;
  } acp_state_type;

  acp_state_type s_q;
  acp_state_type s_d;
  logic conversion_clock_tick;
  logic [3:0] nbits;
  logic [3:0] idx;
  logic aw_take;
  logic w_take;
  logic ar_take;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == OFS_CONFIG) || (addr == OFS_CONTROL) || (addr == OFS_STATUS) ||
                  (addr == OFS_PIN_DISABLE) || (addr == OFS_RESULT_HIGH) || (addr == OFS_RESULT_LOW);
  endfunction : addr_mapped

  function automatic logic [5:0] conv_count(input logic first, input logic long_smp, input logic mode10);
    if (first) begin
      if (long_smp) begin
        conv_count = mode10 ? FIRST_LONG_10 : FIRST_LONG_8;
      end else begin
        conv_count = mode10 ? FIRST_SHORT_10 : FIRST_SHORT_8;
      end
    end else begin
      if (long_smp) begin
        conv_count = mode10 ? NEXT_LONG_10 : NEXT_LONG_8;
      end else begin
        conv_count = mode10 ? NEXT_SHORT_10 : NEXT_SHORT_8;
      end
    end
  endfunction : conv_count

  function automatic logic [7:0] read_reg(input logic [7:0] addr, input acp_state_type st);
    read_reg = 8'h00;
    case (addr)
      OFS_CONFIG: read_reg = st.cfg;
      OFS_STATUS: begin
        read_reg[STAT_BUSY_BIT] = (st.conv != CONV_IDLE);
        read_reg[STAT_DONE_BIT] = st.done;
      end
      OFS_PIN_DISABLE: read_reg = st.pin_dis;
      OFS_RESULT_HIGH: read_reg = {6'h00, st.res_high};
      OFS_RESULT_LOW: read_reg = st.res_low;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // ----------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------
  acp_clk_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .input_clock_select(s_q.cfg[CFG_CLKSEL_LSB +: 2]),
    .clock_divide_select(s_q.cfg[CFG_DIV_LSB +: 2]),
    .alternate_clock(alternate_clock),
    .async_conversion_clock(async_conversion_clock),
    .tick(conversion_clock_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    nbits = s_q.cfg[CFG_MODE10_BIT] ? BITS_10 : BITS_8;
    idx = 4'(s_q.rem - 6'h1);
    aw_take = axi_req.awvalid & ~s_q.aw_held & ~s_q.bvalid;
    w_take = axi_req.wvalid & ~s_q.w_held & ~s_q.bvalid;
    ar_take = axi_req.arvalid & ~s_q.rvalid;

    // comparator synchroniser, level accepted when stages two and three agree
    s_d.cmp_sync = {s_q.cmp_sync[1:0], compare_in};
    if (s_q.cmp_sync[1] == s_q.cmp_sync[2]) begin
      s_d.cmp_lvl = s_q.cmp_sync[2];
    end

    // conversion sequencer
    case (s_q.conv)
      CONV_IDLE: begin
        s_d.sample = 1'b0;
      end
      CONV_STARTUP: begin
        if (s_q.startup_cnt <= 10'h001) begin
          s_d.conv = CONV_RUN;
          s_d.rem = conv_count(1'b1, s_q.cfg[CFG_LONG_BIT], s_q.cfg[CFG_MODE10_BIT]);
          s_d.sample = 1'b1;
        end else begin
          s_d.startup_cnt = s_q.startup_cnt - 10'h001;
        end
      end
      CONV_RUN: begin
        if (conversion_clock_tick) begin
          if (s_q.rem == {2'h0, nbits} + 6'h01) begin
            s_d.sample = 1'b0;
            s_d.code[4'(nbits - 4'h1)] = 1'b1;
          end else if (s_q.rem <= {2'h0, nbits}) begin
            if (!s_q.cmp_lvl) begin
              s_d.code[idx] = 1'b0;
            end
            if (s_q.rem > 6'h01) begin
              s_d.code[4'(idx - 4'h1)] = 1'b1;
            end
          end
          s_d.rem = s_q.rem - 6'h01;
          if (s_q.rem <= 6'h01) begin
            if (s_q.first) begin
              s_d.conv = CONV_TAIL;
              s_d.tail = TAIL_BUS_CYCLES;
            end else begin
              // back to back conversions only need one cycle
              // to hand the result over before sampling again
              s_d.conv = CONV_TAIL;
              s_d.tail = TAIL_NEXT_CYCLES;
            end
          end
        end
      end
      CONV_TAIL: begin
        s_d.tail = s_q.tail - 3'h1;
        if (s_q.tail <= 3'h1) begin
          // algorithm complete, deliver result
          s_d.res_high = s_q.cfg[CFG_MODE10_BIT] ? s_q.code[9:8] : 2'h0;
          s_d.res_low = s_q.code[7:0];
          s_d.done = 1'b1;
          s_d.code = 10'h000;
          if (s_q.cfg[CFG_CONT_BIT]) begin
            s_d.conv = CONV_RUN;
            s_d.first = 1'b0;
            s_d.rem = conv_count(1'b0, s_q.cfg[CFG_LONG_BIT], s_q.cfg[CFG_MODE10_BIT]);
            s_d.sample = 1'b1;
          end else begin
            s_d.conv = CONV_IDLE;
            s_d.sample = 1'b0;
          end
        end
      end
      default: begin
        s_d.conv = CONV_IDLE;
      end
    endcase

    // read channel; reading the low result clears done
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_reg(axi_req.araddr, s_q);
      s_d.rresp = addr_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFS_RESULT_LOW) begin
        // a completion in the same cycle wins over the clear
        s_d.done = (s_q.conv == CONV_TAIL && s_q.tail <= 3'h1);
      end
    end

    // write channels, address and data in either order
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (aw_take) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (w_take) begin
      s_d.w_held = 1'b1;
      s_d.wdata = axi_req.wdata[7:0];
      s_d.wstrb0 = axi_req.wstrb[0];
    end
    if (s_q.aw_held && s_q.w_held) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wstrb0) begin
        case (s_q.awaddr)
          OFS_CONFIG: s_d.cfg = s_q.wdata & CFG_WRITE_MASK;
          OFS_PIN_DISABLE: s_d.pin_dis = s_q.wdata;
          OFS_CONTROL: begin
            if (s_q.wdata[CTRL_STOP_BIT]) begin
              s_d.conv = CONV_IDLE;
              s_d.sample = 1'b0;
              s_d.code = 10'h000;
            end else if (s_q.wdata[CTRL_START_BIT]) begin
              s_d.first = 1'b1;
              s_d.code = 10'h000;
              if (s_q.cfg[CFG_CLKSEL_LSB +: 2] == CLKSEL_ASYNC) begin
                s_d.conv = CONV_STARTUP;
                s_d.startup_cnt = STARTUP_COUNT;
                s_d.sample = 1'b0;
              end else begin
                s_d.conv = CONV_RUN;
                s_d.rem = conv_count(1'b1, s_q.cfg[CFG_LONG_BIT], s_q.cfg[CFG_MODE10_BIT]);
                s_d.sample = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cfg <= CONFIG_RESET;
      s_q.pin_dis <= PIN_DISABLE_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    axi_rsp.awready = ce & ~s_q.aw_held & ~s_q.bvalid;
    axi_rsp.wready = ce & ~s_q.w_held & ~s_q.bvalid;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = ce & ~s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = {24'h000000, s_q.rdata};
    axi_rsp.rresp = s_q.rresp;
  end

  assign sample_hold = s_q.sample;
  assign dac_code = s_q.code;
  assign convert_10bit = s_q.cfg[CFG_MODE10_BIT];
  assign conv_busy = (s_q.conv != CONV_IDLE);
  assign pin_disable = s_q.pin_dis;

endmodule : acp_adc_ctrl

// >>> tb/acp_adc_ctrl_properties.sv
// bus and conversion timing checks bound to the converter control block
`timescale 1ns/1ps
module acp_adc_ctrl_properties (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // reset, low active
  input wire acp_pkg::acp_axi_req_type axi_req, // bus requests
  input wire acp_pkg::acp_axi_rsp_type axi_rsp, // bus answers
  input wire logic sample_hold, // sampling switch
  input wire logic convert_10bit, // resolution
  input wire logic conv_busy, // conversion running
  input wire logic [7:0] pin_disable // port control off
);
  import acp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic aw_hs;
  logic ar_hs;
  assign aw_hs = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && axi_req.wstrb[0];
  assign ar_hs = axi_req.arvalid && axi_rsp.arready;
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_pin_wr;
    aw_hs && axi_req.awaddr == OFS_PIN_DISABLE;
  endsequence
  sequence s_resp;
    !axi_rsp.bvalid ##1 axi_rsp.bvalid;
  endsequence
  a_wr_resp: assert property (aw_hs |=> s_resp) else $error("write answer late");
  a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (ar_hs |=> axi_rsp.rvalid) else $error("read answer late");
  a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
  a_bad_addr: assert property (ar_hs && axi_req.araddr > OFS_RESULT_LOW |=>
    axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read accepted");
  a_pin_write: assert property (s_pin_wr |-> ##2 pin_disable == $past(axi_req.wdata[7:0], 2))
    else $error("pin control not updated");
  a_pin_only: assert property ($changed(pin_disable) |-> $past(aw_hs && axi_req.awaddr == OFS_PIN_DISABLE, 2))
    else $error("pin control changed alone");
  a_res_mode: assert property (aw_hs && axi_req.awaddr == OFS_CONFIG |->
    ##2 convert_10bit == $past(axi_req.wdata[5], 2)) else $error("resolution not updated");
  a_start_busy: assert property (aw_hs && axi_req.awaddr == OFS_CONTROL && axi_req.wdata[1:0] == 2'h1 |->
    ##[2:3] conv_busy) else $error("start ignored");
  a_busy_min: assert property ($rose(conv_busy) |=> conv_busy [*8]) else $error("conversion too short");
  a_idle_hold: assert property (!conv_busy |-> !sample_hold) else $error("sampling while idle");
endmodule : acp_adc_ctrl_properties

bind acp_adc_ctrl acp_adc_ctrl_properties i_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .sample_hold(sample_hold), .convert_10bit(convert_10bit), .conv_busy(conv_busy),
  .pin_disable(pin_disable));

// >>> tb/tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module tb_top;
  import acp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic compare_in = 1'b0;
  logic [1:0] src_q = 2'h0;
  acp_axi_req_type req = '0;
  acp_axi_rsp_type rsp;
  logic sample_hold, convert_10bit, conv_busy, busy_s, sh_prev;
  logic [7:0] pin_disable;
  logic [9:0] dac_code;
  logic [9:0] code_max;
  int n_errors = 0;
  int check_count = 0;
  int n_busy, n_cyc, last_rise, rise_gap, n_rise, m, k, i;
  int fst[4] = '{20, 40, 23, 43};
  int nxt[4] = '{17, 37, 20, 40};
  int per[4] = '{1, 2, 4, 4};
  acp_adc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_req(req), .axi_rsp(rsp),
    .alternate_clock(src_q[1]), .async_conversion_clock(src_q[1]), .compare_in(compare_in),
    .sample_hold(sample_hold), .dac_code(dac_code), .convert_10bit(convert_10bit), .conv_busy(conv_busy),
    .pin_disable(pin_disable));
  initial forever #4 aclk = ~aclk;
  // slow source, one rising edge every four bus cycles
  always @(posedge aclk) src_q <= src_q + 2'h1;
  initial begin
    n_busy = 0; n_cyc = 0; last_rise = 0; rise_gap = 0; n_rise = 0; sh_prev = 1'b0; busy_s = 1'b0;
    code_max = 10'h000;
  end
  always @(negedge aclk) begin
    n_cyc++;
    if (dac_code > code_max) code_max = dac_code;
    busy_s = conv_busy;
    if (conv_busy) n_busy++;
    if (sample_hold && !sh_prev) begin
      rise_gap = n_cyc - last_rise;
      last_rise = n_cyc;
      n_rise++;
    end
    sh_prev = sample_hold;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rng(input string n, input int lo, input int hi, input int s);
    check_count++;
    if (s < lo || s > hi) begin
      n_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask : rng
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, b;
    logic [1:0] r;
    @(posedge aclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'h1;
    req.bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = req.awvalid & rsp.awready;
      hw = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
    end while (!b);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wchk
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = req.arvalid & rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ha) req.arvalid <= 1'b0;
    end while (!v);
    req.rready <= 1'b0;
    chk(n, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rchk
  task automatic wait_idle;
    for (int j = 0; j < 3000 && busy_s; j++) @(posedge aclk);
  endtask : wait_idle
  task automatic conv(input logic [7:0] c, input int lo, input int hi);
    wchk(OFS_CONFIG, {24'h0, c}, RESP_OKAY);
    n_busy = 0;
    wchk(OFS_CONTROL, 32'h1, RESP_OKAY);
    for (int j = 0; j < 3000 && (n_busy == 0 || busy_s); j++) @(posedge aclk);
    rng("conv_cycles", lo, hi, n_busy);
  endtask : conv
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("config_rst", OFS_CONFIG, {24'h0, CONFIG_RESET}, RESP_OKAY);
    rchk("pin_rst", OFS_PIN_DISABLE, {24'h0, PIN_DISABLE_RESET}, RESP_OKAY);
    wchk(OFS_PIN_DISABLE, 32'ha5, RESP_OKAY);
    rchk("pin_rb", OFS_PIN_DISABLE, 32'ha5, RESP_OKAY);
    chk("pin_port", 32'ha5, {24'h0, pin_disable});
    wchk(OFS_PIN_DISABLE, 32'h5a, RESP_OKAY);
    chk("pin_port", 32'h5a, {24'h0, pin_disable});
    wchk(OFS_CONFIG, 32'hff, RESP_OKAY);
    rchk("config_rb", OFS_CONFIG, {24'h0, CFG_WRITE_MASK}, RESP_OKAY);
    rchk("unmapped", 8'h40, 32'h0, RESP_SLVERR);
    wchk(8'h40, 32'h1, RESP_SLVERR);
    for (m = 0; m < 4; m++) conv({2'h0, m[1:0], 4'h0}, fst[m] - 1, fst[m] + 9);
    for (m = 1; m < 4; m++) begin
      k = (m == 3) ? int'(STARTUP_CYCLES) : 0;
      conv({6'h0, m[1:0]}, k + 19 * per[m], k + 21 * per[m] + 9);
    end
    for (m = 1; m < 4; m++) conv({4'h0, m[1:0], 2'h0}, 19 * (1 << m), 21 * (1 << m) + 9);
    for (m = 0; m < 4; m++) begin
      wchk(OFS_CONFIG, {24'h0, 2'h1, m[1:0], 4'h0}, RESP_OKAY);
      wchk(OFS_CONTROL, 32'h1, RESP_OKAY);
      k = n_rise;
      for (i = 0; i < 3000 && n_rise < k + 3; i++) @(posedge aclk);
      rng("next_gap", nxt[m], nxt[m] + 3, rise_gap);
      wchk(OFS_CONTROL, 32'h3, RESP_OKAY);
      wait_idle;
    end
    wchk(OFS_CONFIG, 32'h30, RESP_OKAY);
    compare_in <= 1'b1;
    code_max = 10'h000;
    wchk(OFS_CONTROL, 32'h1, RESP_OKAY);
    rchk("result_early", OFS_RESULT_LOW, 32'h0, RESP_OKAY);
    rchk("status_busy", OFS_STATUS, 32'h1, RESP_OKAY);
    wait_idle;
    rchk("status_done", OFS_STATUS, 32'h2, RESP_OKAY);
    rchk("result_low", OFS_RESULT_LOW, 32'hff, RESP_OKAY);
    rchk("status_clear", OFS_STATUS, 32'h0, RESP_OKAY);
    rchk("result_high", OFS_RESULT_HIGH, 32'h3, RESP_OKAY);
    chk("dac_full", 32'h3ff, {22'h0, code_max});
    test_done;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    test_done;
  end
endmodule : tb_top
